// [include/par_ports_pkg.sv]
`default_nettype none
package par_ports_pkg;
    // Port geometry
    localparam int          PORT_W          = 8;
    // First-port reset state: bits 6..4 outputs driving low
    localparam logic [7:0]  FIRST_DIR_RST   = 8'h70;
    localparam logic [7:0]  PORT_DATA_RST   = 8'h00;
    localparam logic [7:0]  DIR_RST         = 8'h00;
    // First-port pins shared with compare outputs 1..5 and the two bidirectional bits
    localparam int          FIRST_BIDIR_LO  = 3;
    localparam int          FIRST_BIDIR_HI  = 7;
    // Fourth-port special bits
    localparam int          SER_RX_BIT      = 0;
    localparam int          SER_TX_BIT      = 1;
    localparam int          SPI_LO_BIT      = 2;
    localparam int          SPI_HI_BIT      = 5;
    localparam int          STROBE_BIT      = 6;
    localparam int          RW_BIT          = 7;
    localparam logic [7:0]  FOURTH_BUS_MASK = 8'hC0;

    // Operating modes, latched at reset release
    typedef enum logic [1:0] {
        MODE_BOOTSTRAP,
        MODE_SINGLE_CHIP,
        MODE_TEST,
        MODE_EXPANDED
    } op_mode_t;

    // Phase of the multiplexed external bus
    typedef enum logic {
        PHASE_ADDR,
        PHASE_DATA
    } bus_phase_t;

    // One CPU-side write to a port
    typedef struct packed {
        logic       wr;
        logic [7:0] data;
    } port_wr_t;

    // External bus request from the CPU core
    typedef struct packed {
        logic        active;
        bus_phase_t  phase;
        logic        read;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ext_bus_t;

    // Pin drive pair (output level and enable) of an eight-bit port
    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
    } pin_drive_t;
endpackage : par_ports_pkg
`default_nettype wire

// [test/mode_muxed_parallel_ports_asserts.sv]
`default_nettype none
module mode_muxed_parallel_ports_asserts
    import par_ports_pkg::*;
(
    input wire logic       i_clk,
    input wire logic       i_rst_n,
    input wire logic       i_third_port_open_drain,
    input wire logic       i_pulse_accum_dir7,
    input wire logic       i_pulse_accum_dir3,
    input wire logic [7:0] i_compare_en,
    input wire logic [7:0] i_compare_level,
    input wire ext_bus_t   i_bus,
    input wire pin_drive_t o_first_pin,
    input wire pin_drive_t o_second_pin,
    input wire pin_drive_t o_third_pin,
    input wire pin_drive_t o_fourth_pin,
    input wire op_mode_t   o_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] own;
    logic       bus_on;
    // Compare ownership and bus qualification
    assign own    = i_compare_en & 8'hF8;
    assign bus_on = i_bus.active && o_mode inside {MODE_EXPANDED, MODE_TEST};
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    // Steps of a multiplexed bus cycle
    sequence addr_s;
        bus_on && i_bus.phase == PHASE_ADDR;
    endsequence
    sequence data_s;
        bus_on && i_bus.phase == PHASE_DATA;
    endsequence
    high_addr_a:
        assert property (addr_s |-> o_second_pin == {i_bus.addr[15:8], 8'hFF})
        else $error("High address missing");
    low_addr_a:
        assert property (addr_s |-> o_third_pin == {i_bus.addr[7:0], 8'hFF}
            && o_fourth_pin.out[6] && o_fourth_pin.oe[6]) else $error("Address phase wrong");
    write_data_a:
        assert property (data_s and !i_bus.read |-> o_third_pin == {i_bus.wdata, 8'hFF}
            && !o_fourth_pin.out[7]) else $error("Write data phase wrong");
    read_data_a:
        assert property (data_s and i_bus.read |-> o_third_pin.oe == 8'h00
            && o_fourth_pin.out[7]) else $error("Read data phase wrong");
    open_drain_a:
        assert property (o_mode == MODE_SINGLE_CHIP && i_third_port_open_drain
            |-> (o_third_pin.oe & o_third_pin.out) == 8'h00) else $error("Third port drives high");
    first_dir_a:
        assert property (o_first_pin.oe[6:4] == 3'b111 && o_first_pin.oe[2:0] == 3'b000
            && o_first_pin.oe[7] == (i_compare_en[7] | i_pulse_accum_dir7)
            && o_first_pin.oe[3] == (i_compare_en[3] | i_pulse_accum_dir3))
        else $error("First port direction wrong");
    compare_own_a:
        assert property (|own |-> ((o_first_pin.out ^ i_compare_level) & own) == 8'h00
            && (o_first_pin.oe & own) == own) else $error("Compare level lost");
    mode_hold_a:
        assert property ($past(i_rst_n) && $past(i_rst_n, 2) |-> $stable(o_mode))
        else $error("Mode changed");
endmodule : mode_muxed_parallel_ports_asserts
`default_nettype wire

// [test/pin_partner.sv]
`default_nettype none
module pin_partner
    import par_ports_pkg::*;
(
    input  wire logic       i_clk,
    input  wire pin_drive_t i_drv,
    input  wire logic       i_strobe,
    output logic [7:0]      o_pin,
    output logic [7:0]      o_addr_lo
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] pat_q = 8'h3C;
    // Released lines show a pattern that moves every cycle
    always @(posedge i_clk) pat_q <= pat_q + 8'h35;
    assign o_pin = (i_drv.oe & i_drv.out) | (~i_drv.oe & pat_q);
    // Low address byte captured while the strobe is high
    always @(posedge i_clk) if (i_strobe) o_addr_lo <= o_pin;
endmodule : pin_partner
`default_nettype wire

// [test/test_mode_muxed_parallel_ports.sv]
`default_nettype none
module test_mode_muxed_parallel_ports
    import par_ports_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0, rst_n = 1'b0, od = 1'b0, pd7 = 1'b0, pd3 = 1'b0;
    logic [7:0]  cen = '0, clev = '0, pown = '0, poe = '0, pout = '0, dv, lv, wd;
    logic [7:0]  pv1, pv2, pv3, pv4, rd1, rd2, rd3, rd4, rdat;
    logic [7:0]  pin1, pin2, pin3, pin4, alat;
    logic [15:0] e1, e3, e4, addr;
    op_mode_t    mode = MODE_SINGLE_CHIP, omode;
    ext_bus_t    bus = '0;
    port_wr_t    wr [7] = '{default: '0};
    pin_drive_t  p1, p2, p3, p4;
    int          n_mismatch = 0, n_compared = 0;
    always #25 clk = ~clk;
    mode_muxed_parallel_ports uut (
        .i_clk(clk), .i_rst_n(rst_n), .i_mode(mode), .i_first_port_data(wr[0]),
        .i_second_port_data(wr[1]), .i_second_port_direction(wr[2]),
        .i_third_port_data(wr[3]), .i_third_port_direction(wr[4]),
        .i_fourth_port_data(wr[5]), .i_fourth_port_direction(wr[6]),
        .i_third_port_open_drain(od), .i_pulse_accum_dir7(pd7), .i_pulse_accum_dir3(pd3),
        .i_compare_en(cen), .i_compare_level(clev), .i_periph_own(pown),
        .i_periph_oe(poe), .i_periph_out(pout), .i_bus(bus), .i_first_pin(pin1),
        .i_second_pin(pin2), .i_third_pin(pin3), .i_fourth_pin(pin4), .o_first_pin(p1),
        .o_second_pin(p2), .o_third_pin(p3), .o_fourth_pin(p4), .o_first_port_rd(rd1),
        .o_second_port_rd(rd2), .o_third_port_rd(rd3), .o_fourth_port_rd(rd4),
        .o_bus_rdata(rdat), .o_mode(omode));
    // Far side of each port; strobe only on the bus port
    pin_partner far1 (.i_clk(clk), .i_drv(p1), .i_strobe(1'b0), .o_pin(pin1), .o_addr_lo());
    pin_partner far2 (.i_clk(clk), .i_drv(p2), .i_strobe(1'b0), .o_pin(pin2), .o_addr_lo());
    pin_partner far3 (.i_clk(clk), .i_drv(p3), .i_strobe(p4.out[6] & p4.oe[6]),
        .o_pin(pin3), .o_addr_lo(alat));
    pin_partner far4 (.i_clk(clk), .i_drv(p4), .i_strobe(1'b0), .o_pin(pin4), .o_addr_lo());
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    // One-cycle write strobe
    task automatic put(int i, logic [7:0] v);
        wr[i] = {1'b1, v};
        @(negedge clk);
        wr[i].wr = 1'b0;
    endtask : put
    task automatic start(op_mode_t m);
        mode = m;
        rst_n = 1'b0;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        check("mode", 16'(omode), 16'(m));
    endtask : start
    function automatic logic [7:0] rdx(logic [7:0] oe, drv, pin);
        return (oe & drv) | (~oe & pin);
    endfunction : rdx
    // First port: fixed outputs, compare-owned bits, steered bidir bits
    function automatic logic [15:0] first_exp(logic [7:0] lat);
        logic [7:0] own, oe;
        own = cen & 8'hF8;
        oe = 8'h70 | (own & 8'h88) | {pd7, 3'h0, pd3, 3'h0};
        return {((own & clev) | (~own & lat)) & oe, oe};
    endfunction : first_exp
    // Fourth port: bits 5..0 follow an owning peripheral, the rest the GPIO latch
    function automatic logic [15:0] fourth_exp(logic [7:0] lat, dir);
        logic [7:0] own, oe, drv;
        own = pown & 8'h3F;
        oe = (own & poe) | (~own & dir);
        drv = (own & pout) | (~own & lat);
        return {drv & oe, oe};
    endfunction : fourth_exp
    task automatic end_of_test;
        $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test
    // Random port traffic in the two GPIO modes, then the bus modes
    initial begin
        void'($urandom(1));
        for (int k = 0; k < 2; k++) begin
            start(k == 0 ? MODE_SINGLE_CHIP : MODE_BOOTSTRAP);
            repeat (20) begin
                dv = 8'($urandom);
                lv = 8'($urandom);
                cen = 8'($urandom);
                clev = 8'($urandom);
                {od, pd7, pd3} = 3'($urandom);
                pown = 8'($urandom);
                poe = 8'($urandom);
                pout = 8'($urandom);
                for (int i = 0; i < 7; i++) put(i, (i % 2 == 0 && i > 0) ? dv : lv);
                e1 = first_exp(lv);
                e3 = (od && k == 0) ? {8'h00, dv & ~lv} : {lv & dv, dv};
                e4 = fourth_exp(lv, dv);
                pv1 = pin1;
                pv2 = pin2;
                pv3 = pin3;
                pv4 = pin4;
                check("first", {p1.out & p1.oe, p1.oe}, e1);
                check("second", {p2.out & p2.oe, p2.oe}, {lv & dv, dv});
                check("fourth", {p4.out & p4.oe, p4.oe}, e4);
                check("third", {p3.out & p3.oe, p3.oe}, e3);
                @(negedge clk);
                check("first read", rd1, rdx(e1[7:0], e1[15:8], pv1));
                check("second read", rd2, rdx(dv, lv, pv2));
                check("third read", rd3, rdx(e3[7:0], lv, pv3));
                check("fourth read", rd4, rdx(e4[7:0], e4[15:8], pv4));
            end
        end
        for (int k = 0; k < 2; k++) begin
            start(k == 0 ? MODE_EXPANDED : MODE_TEST);
            od = 1'b1;
            addr = 16'($urandom);
            wd = 8'($urandom);
            put(1, 8'hA5);
            bus = {1'b1, PHASE_ADDR, 1'b0, addr, wd};
            @(negedge clk);
            check("high address", p2, {addr[15:8], 8'hFF});
            check("low address", p3, {addr[7:0], 8'hFF});
            check("strobe", {p4.out[6], p4.oe[6]}, 16'h0003);
            check("latched", alat, addr[7:0]);
            bus.phase = PHASE_DATA;
            @(negedge clk);
            check("write data", p3, {wd, 8'hFF});
            check("write line", {p4.out[7], p4.oe[7]}, 16'h0001);
            bus.read = 1'b1;
            @(negedge clk);
            pv3 = pin3;
            check("read line", {p4.out[7], p4.oe[7], p3.oe}, 16'h0300);
            check("second bus read", rd2, addr[15:8]);
            @(negedge clk);
            check("read data", rdat, pv3);
            bus = '0;
        end
        end_of_test();
    end
endmodule : test_mode_muxed_parallel_ports
bind mode_muxed_parallel_ports mode_muxed_parallel_ports_asserts chk (
    .i_clk, .i_rst_n, .i_third_port_open_drain, .i_pulse_accum_dir7, .i_pulse_accum_dir3,
    .i_compare_en, .i_compare_level,
    .i_bus, .o_first_pin, .o_second_pin, .o_third_pin, .o_fourth_pin, .o_mode);
`default_nettype wire

// [verilog/mode_muxed_parallel_ports.sv]
// Notes on behaviour
// - Second, third ports and fourth bits 6,7 are GPIO only in single-chip/bootstrap.
// - First port reads: inputs give pin level, outputs give driver input level.
// - First port write goes to a latch; reaches pin only when bit is output.
// - Pins owned by a compare output ignore software writes.
// - Reset: first-port bits 7 and 3..0 inputs; bits 6..4 outputs driving low.
// - With compares off, pulse-accum control direction bits steer bits 7 and 3.
// - Expanded mode: second port carries address bits 15..8.
// - Second, third, fourth port reads: pin level for inputs, driver input for outputs.
// - Second port latch drives pins only as GPIO output in single-chip/bootstrap.
// - Reset: second port inputs in single/boot; address outputs in expanded/test.
// - Expanded: third port drives low address, then data with direction from read/write.
// - Third port latch drives pins only as GPIO output in single-chip/bootstrap.
// - Reset: third port inputs in single/boot; address/data bus in expanded/test.
// - Open-drain bit turns off pull-ups of all third-port bits; pull-downs stay.
// - Open-drain: zero pulls pin low, one leaves pin undriven.
// - Open-drain takes effect only in single-chip mode.
// - Fourth port: GPIO, serial rx/tx on bits 0,1, SPI on bits 2..5.
// - Fourth port latch reaches pin only when bit is a GPIO output.
// - Expanded/test: fourth bit 6 is address strobe, bit 7 read/write.
// - Read/write line high for a read cycle, low for a write cycle.
`default_nettype none
module mode_muxed_parallel_ports
    import par_ports_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire op_mode_t   i_mode,
    // CPU writes
    input  wire port_wr_t   i_first_port_data,
    input  wire port_wr_t   i_second_port_data,
    input  wire port_wr_t   i_second_port_direction,
    input  wire port_wr_t   i_third_port_data,
    input  wire port_wr_t   i_third_port_direction,
    input  wire port_wr_t   i_fourth_port_data,
    input  wire port_wr_t   i_fourth_port_direction,
    input  wire logic       i_third_port_open_drain,
    input  wire logic       i_pulse_accum_dir7,
    input  wire logic       i_pulse_accum_dir3,
    // Timer compare ownership and levels for first-port bits 7..3
    input  wire logic [7:0] i_compare_en,
    input  wire logic [7:0] i_compare_level,
    // Peripheral pin ownership and levels on the fourth port
    input  wire logic [7:0] i_periph_own,
    input  wire logic [7:0] i_periph_oe,
    input  wire logic [7:0] i_periph_out,
    // External bus request
    input  wire ext_bus_t   i_bus,
    // Pin inputs
    input  wire logic [7:0] i_first_pin,
    input  wire logic [7:0] i_second_pin,
    input  wire logic [7:0] i_third_pin,
    input  wire logic [7:0] i_fourth_pin,
    // Pin drives
    output var pin_drive_t  o_first_pin,
    output var pin_drive_t  o_second_pin,
    output var pin_drive_t  o_third_pin,
    output var pin_drive_t  o_fourth_pin,
    // Read-back values and bus read data
    output logic [7:0]      o_first_port_rd,
    output logic [7:0]      o_second_port_rd,
    output logic [7:0]      o_third_port_rd,
    output logic [7:0]      o_fourth_port_rd,
    output logic [7:0]      o_bus_rdata,
    output var op_mode_t    o_mode
);

    op_mode_t   mode_q;
    logic       boot_seen_q;
    logic       gpio_mode;
    logic       single_chip;
    logic       bus_addr_phase;
    logic       bus_write;
    logic [7:0] second_drv;
    logic [7:0] second_oe;
    logic [7:0] first_lat_q;
    logic [7:0] first_dir;
    logic [7:0] second_lat_q;
    logic [7:0] second_dir_q;
    logic [7:0] third_lat_q;
    logic [7:0] third_dir_q;
    logic [7:0] fourth_lat_q;
    logic [7:0] fourth_dir_q;
    logic [7:0] first_drv;
    logic [7:0] first_oe;
    logic [7:0] third_drv;
    logic [7:0] third_oe;
    logic [7:0] fourth_drv;
    logic [7:0] fourth_oe;

    // Mode caught at the first edge after reset release
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_q <= MODE_SINGLE_CHIP;
        end else if (!boot_seen_q) begin
            mode_q <= i_mode;
        end
    end

    // Strap taken once; later changes on the mode input are ignored
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            boot_seen_q <= 1'b0;
        end else begin
            boot_seen_q <= 1'b1;
        end
    end

    assign gpio_mode   = (mode_q == MODE_SINGLE_CHIP) || (mode_q == MODE_BOOTSTRAP);
    assign single_chip = (mode_q == MODE_SINGLE_CHIP);
    assign o_mode      = mode_q;

    // Bus cycle decode; read/write stays low through a whole write cycle
    assign bus_addr_phase = i_bus.active && (i_bus.phase == PHASE_ADDR);
    assign bus_write      = i_bus.active && !i_bus.read;

    // First-port latch
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            first_lat_q <= PORT_DATA_RST;
        end else if (i_first_port_data.wr) begin
            first_lat_q <= i_first_port_data.data;
        end
    end

    // First-port direction: fixed outputs 6..4, steerable 7 and 3
    always_comb begin
        first_dir                 = FIRST_DIR_RST;
        first_dir[FIRST_BIDIR_HI] = i_compare_en[FIRST_BIDIR_HI] | i_pulse_accum_dir7;
        first_dir[FIRST_BIDIR_LO] = i_compare_en[FIRST_BIDIR_LO] | i_pulse_accum_dir3;
    end

    // Compare-owned pins take the timer level, not the latch
    assign first_drv = (i_compare_en & i_compare_level) | (~i_compare_en & first_lat_q);
    assign first_oe  = first_dir;

    // Second-port latch; stored in every mode, driven only as GPIO
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            second_lat_q <= PORT_DATA_RST;
        end else if (i_second_port_data.wr) begin
            second_lat_q <= i_second_port_data.data;
        end
    end

    // Second-port direction
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            second_dir_q <= DIR_RST;
        end else if (i_second_port_direction.wr) begin
            second_dir_q <= i_second_port_direction.data;
        end
    end

    // Third-port latch; stored in every mode, driven only as GPIO
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            third_lat_q <= PORT_DATA_RST;
        end else if (i_third_port_data.wr) begin
            third_lat_q <= i_third_port_data.data;
        end
    end

    // Third-port direction
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            third_dir_q <= DIR_RST;
        end else if (i_third_port_direction.wr) begin
            third_dir_q <= i_third_port_direction.data;
        end
    end

    // Fourth-port latch
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fourth_lat_q <= PORT_DATA_RST;
        end else if (i_fourth_port_data.wr) begin
            fourth_lat_q <= i_fourth_port_data.data;
        end
    end

    // Fourth-port direction
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fourth_dir_q <= DIR_RST;
        end else if (i_fourth_port_direction.wr) begin
            fourth_dir_q <= i_fourth_port_direction.data;
        end
    end

    // Third port: GPIO with open-drain option, or multiplexed address/data
    always_comb begin
        if (gpio_mode) begin
            third_drv = third_lat_q;
            if (single_chip && i_third_port_open_drain) begin
                third_oe = third_dir_q & ~third_lat_q;
            end else begin
                third_oe = third_dir_q;
            end
        end else if (bus_addr_phase) begin
            third_drv = i_bus.addr[7:0];
            third_oe  = 8'hFF;
        end else if (bus_write) begin
            third_drv = i_bus.wdata;
            third_oe  = 8'hFF;
        end else begin
            third_drv = 8'h00;
            third_oe  = 8'h00;
        end
    end

    // Fourth port: peripherals take priority, bus strobes in expanded/test
    genvar b;
    generate
        for (b = 0; b < PORT_W; b++) begin : g_fourth
            always_comb begin
                if (!gpio_mode && FOURTH_BUS_MASK[b]) begin
                    fourth_oe[b] = 1'b1;
                    if (b == STROBE_BIT) begin
                        fourth_drv[b] = bus_addr_phase;
                    end else begin
                        fourth_drv[b] = !bus_write;
                    end
                end else if (i_periph_own[b] && !FOURTH_BUS_MASK[b]) begin
                    fourth_oe[b]  = i_periph_oe[b];
                    fourth_drv[b] = i_periph_out[b];
                end else begin
                    fourth_oe[b]  = fourth_dir_q[b];
                    fourth_drv[b] = fourth_lat_q[b];
                end
            end
        end
    endgenerate

    // Second port: GPIO latch, or high address byte in the bus modes
    always_comb begin
        if (gpio_mode) begin
            second_drv = second_lat_q;
            second_oe  = second_dir_q;
        end else begin
            second_drv = i_bus.addr[15:8];
            second_oe  = 8'hFF;
        end
    end

    // Pin drives
    assign o_first_pin.out  = first_drv;
    assign o_first_pin.oe   = first_oe;
    assign o_second_pin.out = second_drv;
    assign o_second_pin.oe  = second_oe;
    assign o_third_pin.out  = third_drv;
    assign o_third_pin.oe   = third_oe;
    assign o_fourth_pin.out = fourth_drv;
    assign o_fourth_pin.oe  = fourth_oe;

    // First-port read-back: pin level for inputs, driver input for outputs
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_first_port_rd <= PORT_DATA_RST;
        end else begin
            o_first_port_rd <= (first_oe & first_drv) | (~first_oe & i_first_pin);
        end
    end

    // Second-port read-back, valid in every mode
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_second_port_rd <= PORT_DATA_RST;
        end else begin
            o_second_port_rd <= (second_oe & second_drv)
                              | (~second_oe & i_second_pin);
        end
    end

    // Third-port read-back
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_third_port_rd <= PORT_DATA_RST;
        end else begin
            o_third_port_rd <= (third_oe & third_drv) | (~third_oe & i_third_pin);
        end
    end

    // Fourth-port read-back
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fourth_port_rd <= PORT_DATA_RST;
        end else begin
            o_fourth_port_rd <= (fourth_oe & fourth_drv) | (~fourth_oe & i_fourth_pin);
        end
    end

    // Bus read data, taken from the released third-port pins
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_bus_rdata <= PORT_DATA_RST;
        end else begin
            o_bus_rdata <= i_third_pin;
        end
    end

endmodule : mode_muxed_parallel_ports
`default_nettype wire
